/* File: design/asr_pkg.sv */
// Package of constants for the converter readout host controller
package asr_pkg;
   // Host clock rate in MHz
   localparam int CLK_MHZ          = 250;
   // Serial clock rate in kHz
   localparam int SCLK_KHZ         = 1000;
   // Cycles per serial clock half period
   localparam int HALF_CYCLES      = (CLK_MHZ * 1000) / (SCLK_KHZ * 2);
   localparam int HALF_W           = 8;
   // Worst-case conversion time in ns (8.5 us)
   localparam int CONV_NS          = 8500;
   // Least wait, rounded up to whole cycles
   localparam int CONV_CYCLES      = (CONV_NS * CLK_MHZ + 999) / 1000;
   localparam int WAIT_W           = 12;
   // Frame layout
   localparam int FRAME_BITS       = 16;
   localparam int BYTE_BITS        = 8;
   localparam int RESULT_BITS      = 12;
   localparam int TRAIL_ZEROS      = 3;
   localparam int CNT_W            = 5;
   localparam logic [15:0] FRAME_RST  = 16'h0000;
   localparam logic [11:0] RESULT_RST = 12'h000;
endpackage

/* File: design/asr_frame_unpack.sv */
// Extraction of the 12-bit result from the received 16-bit frame
`timescale 1ns/1ps
module asr_frame_unpack (
   // Received frame, start bit first in bit 15
   input  wire logic [15:0] frame,
   // Right-justified result and start bit seen
   output logic      [11:0] result,
   output logic             start_ok
);
   // Drop start bit and trailing zeros, right-justify
   assign result   = frame[asr_pkg::FRAME_BITS-2 -: asr_pkg::RESULT_BITS];
   assign start_ok = frame[asr_pkg::FRAME_BITS-1];
endmodule

/* File: design/asr_host.sv */
// Host controller that reads the serial converter through its pins
//
// Overview of operation
// - Host drives serial clock and chip select, receives converter data line.
// - Master, clock idle low, sample on first (rising) edge, 1 MHz clock.
// - After chip select low, no clocking until data line goes high.
// - First eight clocks give start bit then result bits 11 to 5.
// - Second eight clocks give result bits 4 to 0 then three zeros.
// - Second byte follows without releasing select; select high afterwards.
// - Extract 12 result bits from 16, drop start and zeros, right-justify.
// - Optional fixed 8.5 us wait instead of watching the data line.
// - Start bit marks the beginning of the received frame.
// - Keep 12 significant bits, remove start bit, right-justify before output.
// - Power-down input held high for normal conversion.
`timescale 1ns/1ps
module asr_host (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // User request and result
   input  wire logic        START,
   input  wire logic        FIXED_WAIT,
   output logic             BUSY,
   output logic             DONE,
   output logic [11:0]      RESULT,
   output logic             START_ERR,
   // Converter pins
   output logic             SCLK,
   output logic             CS_N,
   output logic             POWER_DOWN_N,
   input  wire logic        DOUT
);
   // Sequencer states
   typedef enum logic [2:0] {
      S_IDLE,
      S_WAIT,
      S_LOW,
      S_HIGH,
      S_END
   } asr_state_t;

   // Sequencer state
   asr_state_t                  state_reg;

   // Counters
   logic [asr_pkg::HALF_W-1:0]  half_reg;
   logic [asr_pkg::WAIT_W-1:0]  wait_reg;
   logic [asr_pkg::CNT_W-1:0]   bit_reg;

   // Wait mode latched at the take
   logic                        fixed_reg;

   // Received frame and its shift source
   logic [15:0]                 frame_reg;
   logic [16:0]                 shift_src;

   // Decoded events
   logic                        take;
   logic                        conv_done;
   logic                        rise_evt;
   logic                        fall_evt;
   logic                        last_bit;
   logic                        frame_end;
   logic                        shifting;

   // Unpacked frame
   logic [11:0]                 unpacked;
   logic                        start_ok;

   // Counter end points
   localparam logic [asr_pkg::HALF_W-1:0] HALF_LAST =
      asr_pkg::HALF_W'(asr_pkg::HALF_CYCLES - 1);
   localparam logic [asr_pkg::WAIT_W-1:0] WAIT_LAST =
      asr_pkg::WAIT_W'(asr_pkg::CONV_CYCLES - 1);
   localparam logic [asr_pkg::CNT_W-1:0]  BITS_LAST =
      asr_pkg::CNT_W'(asr_pkg::FRAME_BITS - 1);

   // Last cycle of a serial clock half period in the given phase
   function automatic logic half_end(
      input asr_state_t                 st,
      input asr_state_t                 ph,
      input logic [asr_pkg::HALF_W-1:0] cnt
   );
      half_end = (st == ph) && (cnt == HALF_LAST);
   endfunction

   // End of conversion, by data line or by fixed time
   function automatic logic conv_finished(
      input logic                       fixed,
      input logic                       dout,
      input logic [asr_pkg::WAIT_W-1:0] cnt
   );
      if (fixed) begin
         conv_finished = (cnt == WAIT_LAST);
      end else begin
         conv_finished = dout;
      end
   endfunction

   asr_frame_unpack u_unpack (
      .frame    (frame_reg),
      .result   (unpacked),
      .start_ok (start_ok)
   );

   // Request accepted only while idle
   assign take      = (state_reg == S_IDLE) && START;

   // Wait for end of conversion
   assign conv_done = (state_reg == S_WAIT) && conv_finished(fixed_reg, DOUT, wait_reg);

   // Serial clock edges at the end of each half period
   assign rise_evt  = half_end(state_reg, S_LOW, half_reg);
   assign fall_evt  = half_end(state_reg, S_HIGH, half_reg);

   // Two bytes back to back under one select
   assign last_bit  = (bit_reg == BITS_LAST);
   assign frame_end = fall_evt && last_bit;

   // Half period counter runs only while shifting
   assign shifting  = (state_reg == S_LOW) || (state_reg == S_HIGH);

   // Next frame value: older bits move up, data line enters at bit 0
   assign shift_src = {frame_reg, DOUT};

   // Sequencer
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_reg <= S_IDLE;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (take) begin
                  state_reg <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (conv_done) begin
                  state_reg <= S_LOW;
               end
            end
            S_LOW: begin
               if (rise_evt) begin
                  state_reg <= S_HIGH;
               end
            end
            S_HIGH: begin
               if (frame_end) begin
                  state_reg <= S_END;
               end else if (fall_evt) begin
                  state_reg <= S_LOW;
               end
            end
            S_END: begin
               state_reg <= S_IDLE;
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // Wait mode, fixed for the whole read
   always_ff @(posedge CLK) begin
      if (RST) begin
         fixed_reg <= 1'b0;
      end else if (take) begin
         fixed_reg <= FIXED_WAIT;
      end
   end

   // Conversion wait counter, saturates so it never wraps in data line mode
   always_ff @(posedge CLK) begin
      if (RST) begin
         wait_reg <= '0;
      end else if (take) begin
         wait_reg <= '0;
      end else if (state_reg == S_WAIT && wait_reg != WAIT_LAST) begin
         wait_reg <= wait_reg + 1'b1;
      end
   end

   // Half period counter
   always_ff @(posedge CLK) begin
      if (RST) begin
         half_reg <= '0;
      end else if (conv_done || rise_evt || fall_evt) begin
         half_reg <= '0;
      end else if (shifting) begin
         half_reg <= half_reg + 1'b1;
      end
   end

   // Bit counter, one step per serial clock period
   always_ff @(posedge CLK) begin
      if (RST) begin
         bit_reg <= '0;
      end else if (conv_done) begin
         bit_reg <= '0;
      end else if (fall_evt && !last_bit) begin
         bit_reg <= bit_reg + 1'b1;
      end
   end

   // Serial clock, idle low outside the shift phase
   always_ff @(posedge CLK) begin
      if (RST) begin
         SCLK <= 1'b0;
      end else if (rise_evt) begin
         SCLK <= 1'b1;
      end else if (fall_evt || state_reg != S_HIGH) begin
         SCLK <= 1'b0;
      end
   end

   // Sample on rising edge, start bit first, MSB first
   genvar gi;
   generate
      for (gi = 0; gi < asr_pkg::FRAME_BITS; gi++) begin : g_frame
         always_ff @(posedge CLK) begin
            if (RST || take) begin
               frame_reg[gi] <= asr_pkg::FRAME_RST[gi];
            end else if (rise_evt) begin
               frame_reg[gi] <= shift_src[gi];
            end
         end
      end
   endgenerate

   // Chip select
   always_ff @(posedge CLK) begin
      if (RST) begin
         CS_N <= 1'b1;
      end else if (take) begin
         CS_N <= 1'b0;
      end else if (state_reg == S_END) begin
         CS_N <= 1'b1;
      end
   end

   // Power-down pin held high
   always_ff @(posedge CLK) begin
      if (RST) begin
         POWER_DOWN_N <= 1'b1;
      end else begin
         POWER_DOWN_N <= 1'b1;
      end
   end

   // Result and start bit status
   always_ff @(posedge CLK) begin
      if (RST) begin
         RESULT    <= asr_pkg::RESULT_RST;
         START_ERR <= 1'b0;
      end else if (state_reg == S_END) begin
         RESULT    <= unpacked;
         START_ERR <= !start_ok;
      end
   end

   // Completion pulse
   always_ff @(posedge CLK) begin
      if (RST) begin
         DONE <= 1'b0;
      end else begin
         DONE <= (state_reg == S_END);
      end
   end

   // Busy from the take until the completion pulse
   always_ff @(posedge CLK) begin
      if (RST) begin
         BUSY <= 1'b0;
      end else if (state_reg == S_END) begin
         BUSY <= 1'b0;
      end else begin
         BUSY <= (state_reg != S_IDLE) || START;
      end
   end

   // Hazard: a START held across completion starts a new read right after DONE
endmodule

/* File: verification/asr_host_chk.sv */
// Checker of the host pin protocol
`timescale 1ns/1ps
module asr_host_chk (
   // Clock, reset and user side
   input logic        CLK,
   input logic        RST,
   input logic        START,
   input logic        FIXED_WAIT,
   input logic        BUSY,
   input logic        DONE,
   input logic [11:0] RESULT,
   input logic        START_ERR,
   // Converter pins
   input logic        SCLK,
   input logic        CS_N,
   input logic        POWER_DOWN_N,
   input logic        DOUT
);
   logic        sclk_q;
   logic [4:0]  nrise;
   logic [15:0] frame;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   always_ff @(posedge CLK) sclk_q <= SCLK;
   always_ff @(posedge CLK) nrise <= (RST || CS_N) ? 5'h00 : nrise + {4'h0, SCLK && !sclk_q};
   // Bits taken while the clock is high
   always_ff @(posedge CLK) if (SCLK && !sclk_q) frame <= {frame[14:0], DOUT};
   pwr_up_a: assert property (POWER_DOWN_N) else $error("power-down low");
   sclk_idle_a: assert property (CS_N |-> !SCLK) else $error("clock while idle");
   high_half_a: assert property ($rose(SCLK) |-> ##124 SCLK ##1 !SCLK) else $error("high");
   low_half_a: assert property ($rose(SCLK) |-> !$past(SCLK, 125)) else $error("low");
   conv_seen_a: assert property ($rose(SCLK) && nrise == 5'h00 |-> $past(DOUT, 120))
      else $error("clocked early");
   frame_len_a: assert property ($rose(CS_N) |-> nrise == 5'h10) else $error("count");
   result_ok_a: assert property (DONE |-> RESULT == frame[14:3] && !START_ERR)
      else $error("result");
   done_pulse_a: assert property (DONE |-> !BUSY ##1 !DONE) else $error("done pulse");
   start_take_a: assert property (START && !BUSY && !DONE |=> BUSY && !CS_N) else $error("take");
   cover property (DONE);
   cover property (START && BUSY);
   cover property ($rose(SCLK) && nrise == 5'h0F);
endmodule

/* File: verification/asr_adc_model.sv */
// Behavioural model of the serial converter
`timescale 1ns/1ps
module asr_adc_model (
   // Host pins
   input  logic        SCLK,
   input  logic        CS_N,
   output logic        DOUT,
   // Sample and conversion time
   input  logic [11:0] value,
   input  int          conv_ns
);
   logic [15:0] sh = 16'h0000;
   logic        rdy = 1'b0;
   always @(negedge CS_N) begin
      sh = {1'b1, value, 3'h0};
      rdy = 1'b0;
      #(conv_ns) rdy = 1'b1;
   end
   always @(negedge SCLK) if (rdy) sh = {sh[14:0], 1'b0};
   // Low while converting, inverse of last bit when deselected
   assign DOUT = CS_N ? ~sh[15] : (rdy & sh[15]);
endmodule

/* File: verification/tb.sv */
// Testbench for the converter readout host
`timescale 1ns/1ps
module tb;
   logic        CLK = 1'b0;
   logic        RST = 1'b1;
   logic        START = 1'b0;
   logic        FIX = 1'b0;
   logic        BUSY, DONE, ERR, SCLK, CS_N, PWR, DOUT;
   logic [11:0] RESULT;
   logic [11:0] val = 12'h000;
   int          cns = 1000;
   int          n_fail = 0;
   int          n_compared = 0;
   int          cyc = 0;
   always #2 CLK = ~CLK;
   asr_host uut (.CLK(CLK), .RST(RST), .START(START), .FIXED_WAIT(FIX), .BUSY(BUSY),
      .DONE(DONE), .RESULT(RESULT), .START_ERR(ERR), .SCLK(SCLK), .CS_N(CS_N),
      .POWER_DOWN_N(PWR), .DOUT(DOUT));
   asr_adc_model adc (.SCLK(SCLK), .CS_N(CS_N), .DOUT(DOUT), .value(val), .conv_ns(cns));
   task automatic stop_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One read; hold keeps START high while busy
   task automatic rd(input logic [11:0] v, input logic fx, input int c, input logic hold);
      int w;
      logic clocked;
      w = 0;
      clocked = 1'b0;
      val = v;
      FIX = fx;
      cns = c;
      START = 1'b1;
      @(negedge CLK);
      START = hold;
      chk("busy", 12'h001, {11'h000, BUSY});
      chk("select", 12'h000, {11'h000, CS_N});
      while (DONE !== 1'b1 && cyc < 60000) begin
         if (SCLK === 1'b1) clocked = 1'b1;
         if (!clocked) w++;
         @(negedge CLK);
      end
      START = 1'b0;
      chk("deselect", 12'h001, {11'h000, CS_N});
      @(negedge CLK);
      chk("done pulse", 12'h000, {11'h000, DONE});
      chk("wait", 12'h001, 12'(w > (fx ? asr_pkg::CONV_CYCLES : c / 4) + 124));
      chk("result", v, RESULT);
      chk("start flag", 12'h000, {11'h000, ERR});
   endtask
   task automatic t_basic;
      rd(12'hA5C, 1'b0, 3000, 1'b0);
      $display("test basic done");
   endtask
   task automatic t_bounds;
      rd(12'hFFF, 1'b0, 400, 1'b0);
      rd(12'h001, 1'b0, 8000, 1'b0);
      $display("test bounds done");
   endtask
   task automatic t_fixed;
      rd(12'h5A3, 1'b1, 8000, 1'b0);
      $display("test fixed wait done");
   endtask
   task automatic t_hold;
      rd(12'h800, 1'b0, 200, 1'b1);
      $display("test held start done");
   endtask
   initial begin
      repeat (4) @(negedge CLK);
      RST = 1'b0;
      chk("power-down", 12'h001, {11'h000, PWR});
      t_basic();
      t_bounds();
      t_fixed();
      t_hold();
      stop_test();
   end
endmodule
bind asr_host asr_host_chk chk_i (.CLK(CLK), .RST(RST), .START(START),
   .FIXED_WAIT(FIXED_WAIT), .BUSY(BUSY), .DONE(DONE), .RESULT(RESULT),
   .START_ERR(START_ERR), .SCLK(SCLK), .CS_N(CS_N), .POWER_DOWN_N(POWER_DOWN_N), .DOUT(DOUT));
